//--- rtl/ccsr_defs.vh
// constants for the card configuration and status register bank
`ifndef CCSR_DEFS_VH
`define CCSR_DEFS_VH

// ============================================================
// register offsets in attribute space
`define CCSR_ADDR_W 8
`define CCSR_OFS_CONFIG_STATUS 8'hFA
`define CCSR_OFS_PIN_REPLACE 8'hFC
`define CCSR_OFS_SOCKET_COPY 8'hFE

// ============================================================
// config_and_status field positions
`define CCSR_CS_CHANGED 7
`define CCSR_CS_SIGCHG 6
`define CCSR_CS_IOIS8 5
`define CCSR_CS_RSVD 4
`define CCSR_CS_AUDIO 3
`define CCSR_CS_PWRDWN 2
`define CCSR_CS_INTR 1
`define CCSR_CS_IRQACK 0

// ============================================================
// pin_replacement_status layout: changed bits above live bits
`define CCSR_PR_PAIRS 4
`define CCSR_PR_CHG_LSB 4
`define CCSR_PR_LIVE_LSB 0
`define CCSR_PR_BVD1 3
`define CCSR_PR_BVD2 2
`define CCSR_PR_READY 1
`define CCSR_PR_WPROT 0

// ============================================================
// socket_copy_ident layout
`define CCSR_SC_RSVD 7
`define CCSR_SC_STORE_W 7

// ============================================================
// start-up depth: edges before the pin pair is compared
`define CCSR_SETTLE_W 5
`define CCSR_SETTLE_ZERO 5'h00

// ============================================================
// reset and fixed values
`define CCSR_BYTE_ZERO 8'h00
`define CCSR_NIB_ZERO 4'h0
`define CCSR_SC_RESET 7'h00
`define CCSR_BIT_ZERO 1'b0
`define CCSR_BIT_ONE 1'b1

`endif

//--- rtl/ccsr_regs.v
// configuration-and-status, pin replacement and socket-copy registers
//
// What this block does
// - reserved config_and_status bit reads zero
// - audio bit stored only, speaker never driven
// - power-down bit stored, driven out on power_down_request
// - interrupt bit shows pending function interrupt
// - interrupt bit writes dropped, acknowledge always zero
// - acknowledge bit ignores writes, reads zero
// - status-change output is never asserted
// - changed bit sets when paired live toggles
// - host may set changed bits directly
// - live bit written one also writes changed
// - battery-detect live bits show internal detectors
// - ready live bit shows internal ready state
// - write-protect live bit shows switch state
// - changed bits D7..D4, live D3..D0
// - copy number field from D6, read/write
// - socket number field from D3, read/write
// - changed summary set when any changed bit, I/O interface only
`timescale 1ns/100ps
`include "ccsr_defs.vh"
`default_nettype none

module ccsr_regs
(
    input wire sys_clk,
    input wire rst,
    input wire clk_en,
    input wire soft_reset,
    input wire [`CCSR_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire io_interface,
    input wire irq_pending,
    input wire batt_detect1_int,
    input wire batt_detect2_int,
    input wire ready_int,
    input wire write_protect_pin,
    output reg [7:0] reg_rdata,
    output reg speaker_out,
    output reg status_change_n,
    output reg power_down_request
);

// ============================================================
// state
reg sig_chg_gate;
reg io_is_8bit;
reg audio_enable;
reg [`CCSR_SC_STORE_W-1:0] socket_copy;
reg [`CCSR_PR_PAIRS-1:0] changed;
reg [`CCSR_PR_PAIRS-1:0] live_prev;
reg [`CCSR_SETTLE_W-1:0] settle;
reg wp_sync1;
reg wp_sync2;
reg wp_sync3;
reg wp_state;

wire [`CCSR_PR_PAIRS-1:0] live;
wire [`CCSR_PR_PAIRS-1:0] next_changed;
wire sel_cs;
wire sel_pr;
wire sel_sc;
wire wr_cs;
wire wr_pr;
wire wr_sc;
wire any_changed;
reg [7:0] next_rdata;

// ============================================================
// address decode
assign sel_cs = (reg_addr == `CCSR_OFS_CONFIG_STATUS);
assign sel_pr = (reg_addr == `CCSR_OFS_PIN_REPLACE);
assign sel_sc = (reg_addr == `CCSR_OFS_SOCKET_COPY);
assign wr_cs = reg_wr && sel_cs;
assign wr_pr = reg_wr && sel_pr;
assign wr_sc = reg_wr && sel_sc;

// ============================================================
// write-protect switch arrives from a pin: three-stage synchroniser
// a change is taken only once stages two and three agree
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        wp_sync1 <= `CCSR_BIT_ZERO;
        wp_sync2 <= `CCSR_BIT_ZERO;
        wp_sync3 <= `CCSR_BIT_ZERO;
        wp_state <= `CCSR_BIT_ZERO;
    end
    else if (clk_en)
    begin
        wp_sync1 <= write_protect_pin;
        wp_sync2 <= wp_sync1;
        wp_sync3 <= wp_sync2;
        if (wp_sync2 == wp_sync3)
        begin
            wp_state <= wp_sync3;
        end
    end
end

// ============================================================
// change-detect start-up
// the synchroniser leaves reset at zero, so a pin held high would
// look like a change; the write-protect pair waits until the pin
// value has crossed every stage before it is compared
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        settle <= `CCSR_SETTLE_ZERO;
    end
    else if (clk_en)
    begin
        settle <= {settle[`CCSR_SETTLE_W-2:0], `CCSR_BIT_ONE};
    end
end

// ============================================================
// live status vector, same order as the changed bits
assign live[`CCSR_PR_BVD1] = batt_detect1_int;
assign live[`CCSR_PR_BVD2] = batt_detect2_int;
assign live[`CCSR_PR_READY] = ready_int;
assign live[`CCSR_PR_WPROT] = wp_state;

// ============================================================
// change latches, one per pair
genvar gi;
generate
    for (gi = 0; gi < `CCSR_PR_PAIRS; gi = gi + 1)
    begin : g_pair
        wire hw_set;
        wire host_wr_val;
        wire host_set;
        wire ref_ok;
        // first sample after reset is only a reference, not a change;
        // the pin pair waits until the synchroniser has filled
        assign ref_ok = (gi == `CCSR_PR_WPROT) ?
            settle[`CCSR_SETTLE_W-1] : settle[0];
        assign hw_set = ref_ok && (live[gi] != live_prev[gi]);
        // live bit written one: changed takes the written value
        assign host_wr_val = wr_pr && reg_wdata[`CCSR_PR_LIVE_LSB + gi];
        // live bit written zero: a one on the changed bit still sets it
        assign host_set = wr_pr && reg_wdata[`CCSR_PR_CHG_LSB + gi];
        // hardware set wins over a host clear in the same cycle
        assign next_changed[gi] = hw_set ? `CCSR_BIT_ONE :
            host_wr_val ? reg_wdata[`CCSR_PR_CHG_LSB + gi] :
            host_set ? `CCSR_BIT_ONE : changed[gi];
    end
endgenerate

assign any_changed = |changed;

always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        changed <= `CCSR_NIB_ZERO;
        live_prev <= `CCSR_NIB_ZERO;
    end
    else if (clk_en)
    begin
        live_prev <= live;
        if (soft_reset)
        begin
            changed <= `CCSR_NIB_ZERO;
        end
        else
        begin
            changed <= next_changed;
        end
    end
end

// ============================================================
// config_and_status storage
// interrupt and acknowledge bits have no storage: with a single
// function the acknowledge is always zero, so every write to the
// interrupt bit is discarded
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        sig_chg_gate <= `CCSR_BIT_ZERO;
        io_is_8bit <= `CCSR_BIT_ZERO;
        audio_enable <= `CCSR_BIT_ZERO;
        power_down_request <= `CCSR_BIT_ZERO;
    end
    else if (clk_en)
    begin
        if (soft_reset)
        begin
            sig_chg_gate <= `CCSR_BIT_ZERO;
            io_is_8bit <= `CCSR_BIT_ZERO;
            audio_enable <= `CCSR_BIT_ZERO;
            power_down_request <= `CCSR_BIT_ZERO;
        end
        else if (wr_cs)
        begin
            sig_chg_gate <= reg_wdata[`CCSR_CS_SIGCHG];
            io_is_8bit <= reg_wdata[`CCSR_CS_IOIS8];
            audio_enable <= reg_wdata[`CCSR_CS_AUDIO];
            power_down_request <= reg_wdata[`CCSR_CS_PWRDWN];
        end
    end
end

// ============================================================
// socket_copy_ident storage, D7 not stored
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        socket_copy <= `CCSR_SC_RESET;
    end
    else if (clk_en)
    begin
        if (soft_reset)
        begin
            socket_copy <= `CCSR_SC_RESET;
        end
        else if (wr_sc)
        begin
            // copy number D6..D4, socket number D3..D0
            socket_copy <= reg_wdata[`CCSR_SC_STORE_W-1:0];
        end
    end
end

// ============================================================
// read mux; unmapped offsets read zero
// a write in the same cycle shows only on the next read
always @*
begin
    next_rdata = `CCSR_BYTE_ZERO;
    if (sel_cs)
    begin
        // summary bit is meaningless outside the I/O interface
        next_rdata[`CCSR_CS_CHANGED] = io_interface && any_changed;
        next_rdata[`CCSR_CS_SIGCHG] = sig_chg_gate;
        next_rdata[`CCSR_CS_IOIS8] = io_is_8bit;
        next_rdata[`CCSR_CS_RSVD] = `CCSR_BIT_ZERO;
        next_rdata[`CCSR_CS_AUDIO] = audio_enable;
        next_rdata[`CCSR_CS_PWRDWN] = power_down_request;
        // live flag only: host writes can never reach it
        next_rdata[`CCSR_CS_INTR] = irq_pending;
        next_rdata[`CCSR_CS_IRQACK] = `CCSR_BIT_ZERO;
    end
    else if (sel_pr)
    begin
        next_rdata = {changed, live};
    end
    else if (sel_sc)
    begin
        next_rdata = {`CCSR_BIT_ZERO, socket_copy};
    end
end

// ============================================================
// registered read data, held until the next accepted read
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        reg_rdata <= `CCSR_BYTE_ZERO;
    end
    else if (clk_en)
    begin
        if (reg_rd)
        begin
            reg_rdata <= next_rdata;
        end
    end
end

// ============================================================
// fixed outputs, from flops so the pins cannot glitch
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        speaker_out <= `CCSR_BIT_ZERO;
        status_change_n <= `CCSR_BIT_ONE;
    end
    else if (clk_en)
    begin
        // no audio path exists, whatever audio_enable holds
        speaker_out <= `CCSR_BIT_ZERO;
        // status change not supported: kept high (inactive)
        status_change_n <= `CCSR_BIT_ONE;
    end
end

endmodule

`default_nettype wire

//--- test/ccsr_chk_assertions.sv
// checker for the configuration register bank ports
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// checker
module ccsr_chk
(
    input wire sys_clk,
    input wire rst,
    input wire clk_en,
    input wire soft_reset,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire irq_pending,
    input wire batt_detect1_int,
    input wire batt_detect2_int,
    input wire ready_int,
    input wire [7:0] reg_rdata,
    input wire speaker_out,
    input wire status_change_n,
    input wire power_down_request
);
    wire rd = reg_rd && clk_en;
    wire rd_cs = rd && reg_addr == 8'hFA;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_SPEAKER: assert property (!speaker_out)
        else $error("speaker output driven");
    AST_STSCHG: assert property (status_change_n)
        else $error("status change asserted");
    AST_PWR: assert property (reg_wr && clk_en && reg_addr == 8'hFA
        && !soft_reset |=> power_down_request == $past(reg_wdata[2]))
        else $error("power down bit not stored");
    AST_CSR_ZERO: assert property (rd_cs |=> !reg_rdata[4] && !reg_rdata[0])
        else $error("fixed zero bit read as one");
    AST_INTR: assert property (rd_cs |=> reg_rdata[1] == $past(irq_pending))
        else $error("interrupt bit wrong");
    AST_SC7: assert property (rd && reg_addr == 8'hFE |=> !reg_rdata[7])
        else $error("socket copy top bit set");
    AST_LIVE: assert property (rd && reg_addr == 8'hFC |=>
        reg_rdata[3:1] == $past({batt_detect1_int, batt_detect2_int, ready_int}))
        else $error("live bits wrong");
    AST_SOFT: assert property (soft_reset && clk_en |=> !power_down_request)
        else $error("soft reset left power down set");
    AST_HOLD: assert property (!rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    cover property (reg_wr && clk_en && reg_addr == 8'hFE);
    cover property (rd && reg_addr == 8'hFC);
    cover property (soft_reset && clk_en);
endmodule
bind ccsr_regs ccsr_chk ccsr_chk_inst (.sys_clk(sys_clk), .rst(rst),
    .clk_en(clk_en), .soft_reset(soft_reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .irq_pending(irq_pending), .batt_detect1_int(batt_detect1_int),
    .batt_detect2_int(batt_detect2_int), .ready_int(ready_int),
    .reg_rdata(reg_rdata), .speaker_out(speaker_out),
    .status_change_n(status_change_n),
    .power_down_request(power_down_request));
`default_nettype wire

//--- test/ccsr_host.sv
// host socket model issuing register accesses
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// host
module ccsr_host
(
    input wire logic sys_clk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr = 8'h00,
    output logic [7:0] reg_wdata = 8'h00,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        // released bus shows no stale data
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // socket copy write, D7 always sent as zero
    task automatic wr_socket(input logic [6:0] d);
        wr(8'hFE, {1'b0, d});
    endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the configuration register bank
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// bench
module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic soft_reset = 1'b0;
    logic clk_en = 1'b1;
    logic io_interface = 1'b0;
    logic irq_pending = 1'b0;
    logic b1 = 1'b1;
    logic b2 = 1'b0;
    logic rdy = 1'b0;
    logic wp = 1'b0;
    wire [7:0] addr, wdata, rdata;
    wire wr, rd, spk, stsn, pwr;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    ccsr_regs ccsr_regs_inst (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .soft_reset(soft_reset), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .io_interface(io_interface),
        .irq_pending(irq_pending), .batt_detect1_int(b1),
        .batt_detect2_int(b2), .ready_int(rdy), .write_protect_pin(wp),
        .reg_rdata(rdata), .speaker_out(spk), .status_change_n(stsn),
        .power_down_request(pwr));
    ccsr_host ccsr_host_inst (.sys_clk(sys_clk), .reg_rdata(rdata),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));
    always #12.5 sys_clk = ~sys_clk;
    // hang guard, far above the hundred-odd cycles needed
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [7:0] s, e);
        check_count++;
        if (s !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rdc(input logic [7:0] a, e);
        logic [7:0] d;
        ccsr_host_inst.rd(a, d);
        chk("rdata", d, e);
    endtask
    task automatic sc_reset_values();
        rdc(8'hFC, 8'h08);
        rdc(8'hFE, 8'h00);
        rdc(8'h10, 8'h00);
    endtask
    task automatic sc_socket();
        ccsr_host_inst.wr_socket(7'h5A);
        rdc(8'hFE, 8'h5A);
    endtask
    task automatic sc_csr();
        // reserved D4 written zero, D1 and D0 written one
        ccsr_host_inst.wr(8'hFA, 8'hEF);
        rdc(8'hFA, 8'h6C);
        chk("pwr", {7'h00, pwr}, 8'h01);
        chk("spk", {6'h00, spk, stsn}, 8'h01);
        @(posedge sys_clk) irq_pending <= 1'b1;
        rdc(8'hFA, 8'h6E);
        @(posedge sys_clk) irq_pending <= 1'b0;
        ccsr_host_inst.wr(8'hFA, 8'h00);
        // the flop updates at the taking edge: look half a cycle later
        @(negedge sys_clk);
        chk("pwr", {7'h00, pwr}, 8'h00);
    endtask
    task automatic sc_change();
        @(posedge sys_clk) rdy <= 1'b1;
        @(posedge sys_clk);
        rdc(8'hFC, 8'h2A);
        @(posedge sys_clk) io_interface <= 1'b1;
        rdc(8'hFA, 8'h80);
        // gate open and summary set: the status-change pin stays idle
        ccsr_host_inst.wr(8'hFA, 8'h40);
        rdc(8'hFA, 8'hC0);
        chk("stsn", {7'h00, stsn}, 8'h01);
        ccsr_host_inst.wr(8'hFC, 8'h0F);
        rdc(8'hFC, 8'h0A);
        rdc(8'hFA, 8'h40);
        ccsr_host_inst.wr(8'hFC, 8'h80);
        rdc(8'hFC, 8'h8A);
        ccsr_host_inst.wr(8'hFC, 8'h00);
        rdc(8'hFC, 8'h8A);
        @(posedge sys_clk) b2 <= 1'b1;
        @(posedge sys_clk);
        rdc(8'hFC, 8'hCE);
        @(posedge sys_clk) wp <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rdc(8'hFC, 8'hDF);
    endtask
    task automatic sc_soft_reset();
        @(posedge sys_clk) soft_reset <= 1'b1;
        @(posedge sys_clk) soft_reset <= 1'b0;
        rdc(8'hFC, 8'h0F);
        rdc(8'hFE, 8'h00);
    endtask
    // clock enable low: neither the write nor the read is taken
    task automatic sc_clk_en();
        @(posedge sys_clk) clk_en <= 1'b0;
        ccsr_host_inst.wr_socket(7'h11);
        rdc(8'hFA, 8'h5A);
        @(posedge sys_clk) clk_en <= 1'b1;
        rdc(8'hFE, 8'h5A);
    endtask
    // mid-run hard reset with the write-protect pin held high
    task automatic sc_hard_reset();
        ccsr_host_inst.wr_socket(7'h23);
        ccsr_host_inst.wr(8'hFC, 8'hF0);
        rdc(8'hFC, 8'hFF);
        @(posedge sys_clk) rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rdc(8'hFC, 8'h0F);
        rdc(8'hFE, 8'h00);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        sc_reset_values();
        sc_socket();
        sc_clk_en();
        sc_csr();
        sc_change();
        sc_soft_reset();
        sc_hard_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
